// file: rtl/ocdxal_pkg.sv
// package for the opcode decoder: operation codes, opcode patterns, carriers
// assumes a byte-wide instruction stream from the prefetch queue
package ocdxal_pkg;

   // first-byte patterns, then the constant byte of the adjust forms
   localparam logic [7:0] OP_SEG_TO_RM = 8'h8C;
   localparam logic [7:0] OP_EFF_OFFSET = 8'h8D;
   localparam logic [7:0] OP_RM_TO_SEG = 8'h8E;
   localparam logic [7:0] OP_STACK_LOAD = 8'h8F;
   localparam logic [7:0] OP_BYTE_TO_WORD = 8'h98;
   localparam logic [7:0] OP_WORD_TO_DBL = 8'h99;
   localparam logic [7:0] OP_HIGH_TO_FLAGS = 8'h9E;
   localparam logic [7:0] OP_FLAGS_TO_HIGH = 8'h9F;
   localparam logic [7:0] OP_PTR_EXTRA = 8'hC4;
   localparam logic [7:0] OP_PTR_DATA = 8'hC5;
   localparam logic [7:0] OP_ASCII_PROD = 8'hD4;
   localparam logic [7:0] OP_ASCII_QUOT = 8'hD5;
   localparam logic [7:0] OP_TABLE_LOOKUP = 8'hD7;
   localparam logic [7:0] OP_STACK_STORE = 8'hFF;
   localparam logic [7:0] OP_BCD_SUM = 8'h27;
   localparam logic [7:0] OP_BCD_DIFF = 8'h2F;
   localparam logic [7:0] OP_ASCII_SUM = 8'h37;
   localparam logic [7:0] OP_ASCII_DIFF = 8'h3F;
   localparam logic [7:0] ASCII_ADJ_BASE = 8'h0A;
   // six-bit and seven-bit group prefixes
   localparam logic [5:0] GRP_SUM_CARRY_REG = 6'h04;
   localparam logic [5:0] GRP_DIFF_REG = 6'h0A;
   localparam logic [5:0] GRP_DIFF_BORROW_REG = 6'h06;
   localparam logic [5:0] GRP_IMM = 6'h20;
   localparam logic [5:0] GRP_SHIFT = 6'h34;
   localparam logic [6:0] GRP_SUM_CARRY_ACC = 7'h0A;
   localparam logic [6:0] GRP_DIFF_BORROW_ACC = 7'h0E;
   localparam logic [6:0] GRP_UNARY = 7'h7B;
   // sub-opcodes
   localparam logic [2:0] SUB_0 = 3'h0;
   localparam logic [2:0] SUB_1 = 3'h1;
   localparam logic [2:0] SUB_2 = 3'h2;
   localparam logic [2:0] SUB_3 = 3'h3;
   localparam logic [2:0] SUB_4 = 3'h4;
   localparam logic [2:0] SUB_5 = 3'h5;
   localparam logic [2:0] SUB_6 = 3'h6;
   localparam logic [2:0] SUB_7 = 3'h7;

   typedef enum logic [5:0] {
      OPR_NONE, OPR_MOVE_TO_SEG, OPR_MOVE_FROM_SEG, OPR_TABLE_LOOKUP_BYTE,
      OPR_EFFECTIVE_OFFSET_LOAD, OPR_POINTER_LOAD_DATASEG, OPR_POINTER_LOAD_EXTRASEG,
      OPR_FLAGS_TO_HIGH_BYTE, OPR_HIGH_BYTE_TO_FLAGS, OPR_SUM_WITH_CARRY,
      OPR_ASCII_SUM_FIX, OPR_BCD_SUM_FIX, OPR_DIFFERENCE, OPR_DIFFERENCE_WITH_BORROW,
      OPR_ASCII_DIFFERENCE_FIX, OPR_BCD_DIFFERENCE_FIX, OPR_UNSIGNED_PRODUCT,
      OPR_SIGNED_PRODUCT, OPR_UNSIGNED_QUOTIENT, OPR_SIGNED_QUOTIENT, OPR_SIGN_CHANGE,
      OPR_INVERT, OPR_ASCII_PRODUCT_FIX, OPR_ASCII_QUOTIENT_PREP, OPR_BYTE_TO_WORD_EXTEND,
      OPR_WORD_TO_DOUBLE_EXTEND, OPR_LEFT_SHIFT, OPR_LOGICAL_RIGHT_SHIFT,
      OPR_SIGNED_RIGHT_SHIFT, OPR_CYCLIC_LEFT, OPR_CYCLIC_RIGHT, OPR_CARRY_CYCLIC_LEFT,
      OPR_STACK_STORE, OPR_STACK_LOAD
   } ocdxal_op_t;

   // first-byte classification result
   typedef struct packed {
      logic known;
      logic needs_modrm;
      logic needs_second_const;
      logic [1:0] imm_kind;
      ocdxal_op_t op;
   } ocdxal_class_t;

   localparam logic [1:0] IMM_NONE = 2'h0;
   localparam logic [1:0] IMM_BY_W = 2'h1;
   localparam logic [1:0] IMM_BY_SW = 2'h2;

   // decoded instruction handed to the datapath
   typedef struct packed {
      ocdxal_op_t op;
      logic word_size;
      logic to_reg;
      logic sign_ext;
      logic count_in_reg;
      logic [1:0] addressing_kind;
      logic [2:0] gpr_index;
      logic [2:0] operand_field;
      logic [15:0] immediate;
   } ocdxal_decoded_t;

endpackage

// file: rtl/ocdxal_first_byte.sv
// combinational classification of a first opcode byte
// assumes the caller resolves sub-opcode groups once the addressing byte arrives
`timescale 1ns/1ps
module ocdxal_first_byte
   import ocdxal_pkg::*;
(
   // opcode in
   input wire logic [7:0] opcode,
   // class out
   output ocdxal_class_t cls
);

   always_comb
   begin
      cls = '{known: 1'b1, needs_modrm: 1'b0, needs_second_const: 1'b0,
              imm_kind: IMM_NONE, op: OPR_NONE};
      case (opcode)
         OP_RM_TO_SEG: cls.op = OPR_MOVE_TO_SEG;
         OP_SEG_TO_RM: cls.op = OPR_MOVE_FROM_SEG;
         OP_TABLE_LOOKUP: cls.op = OPR_TABLE_LOOKUP_BYTE;
         OP_EFF_OFFSET: cls.op = OPR_EFFECTIVE_OFFSET_LOAD;
         OP_PTR_DATA: cls.op = OPR_POINTER_LOAD_DATASEG;
         OP_PTR_EXTRA: cls.op = OPR_POINTER_LOAD_EXTRASEG;
         OP_FLAGS_TO_HIGH: cls.op = OPR_FLAGS_TO_HIGH_BYTE;
         OP_HIGH_TO_FLAGS: cls.op = OPR_HIGH_BYTE_TO_FLAGS;
         OP_ASCII_SUM: cls.op = OPR_ASCII_SUM_FIX;
         OP_BCD_SUM: cls.op = OPR_BCD_SUM_FIX;
         OP_ASCII_DIFF: cls.op = OPR_ASCII_DIFFERENCE_FIX;
         OP_BCD_DIFF: cls.op = OPR_BCD_DIFFERENCE_FIX;
         OP_ASCII_PROD: cls.op = OPR_ASCII_PRODUCT_FIX;
         OP_ASCII_QUOT: cls.op = OPR_ASCII_QUOTIENT_PREP;
         OP_BYTE_TO_WORD: cls.op = OPR_BYTE_TO_WORD_EXTEND;
         OP_WORD_TO_DBL: cls.op = OPR_WORD_TO_DOUBLE_EXTEND;
         OP_STACK_STORE: cls.op = OPR_STACK_STORE;
         OP_STACK_LOAD: cls.op = OPR_STACK_LOAD;
         default:
         begin
            if (opcode[7:2] == GRP_SUM_CARRY_REG)
               cls.op = OPR_SUM_WITH_CARRY;
            else if (opcode[7:2] == GRP_DIFF_REG)
               cls.op = OPR_DIFFERENCE;
            else if (opcode[7:2] == GRP_DIFF_BORROW_REG)
               cls.op = OPR_DIFFERENCE_WITH_BORROW;
            else if (opcode[7:2] == GRP_IMM)
               cls.imm_kind = IMM_BY_SW;
            else if (opcode[7:2] == GRP_SHIFT)
               cls.op = OPR_NONE;
            else if (opcode[7:1] == GRP_UNARY)
               cls.op = OPR_NONE;
            else if (opcode[7:1] == GRP_SUM_CARRY_ACC)
            begin
               cls.op = OPR_SUM_WITH_CARRY;
               cls.imm_kind = IMM_BY_W;
            end
            else if (opcode[7:1] == GRP_DIFF_BORROW_ACC)
            begin
               cls.op = OPR_DIFFERENCE_WITH_BORROW;
               cls.imm_kind = IMM_BY_W;
            end
            else
               cls.known = 1'b0;
         end
      endcase
      // addressing byte follows every recognised opcode but accumulator forms, single-byte ops and the two adjust forms that take a constant byte
      cls.needs_modrm = cls.known && cls.imm_kind != IMM_BY_W &&
         !(opcode inside {OP_TABLE_LOOKUP, OP_FLAGS_TO_HIGH, OP_HIGH_TO_FLAGS,
                          OP_ASCII_SUM, OP_BCD_SUM, OP_ASCII_DIFF, OP_BCD_DIFF,
                          OP_BYTE_TO_WORD, OP_WORD_TO_DBL, OP_ASCII_PROD,
                          OP_ASCII_QUOT});
      cls.needs_second_const = opcode == OP_ASCII_PROD || opcode == OP_ASCII_QUOT;
   end

endmodule

// file: rtl/ocdxal_decoder.sv
// opcode decoder for transfer, arithmetic and shift/rotate groups
// assumes bytes arrive in order on a valid/ready stream from the prefetch queue
`timescale 1ns/1ps
module ocdxal_decoder
   import ocdxal_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // byte stream from the prefetch queue
   input wire logic [7:0] in_byte,
   input wire logic in_valid,
   output logic in_ready,
   // decoded instruction to the datapath
   output ocdxal_decoded_t dec,
   output logic dec_valid,
   input wire logic dec_ready,
   output logic dec_illegal
);

   typedef enum logic [2:0] {ST_OPCODE, ST_MODRM, ST_CONST, ST_IMM_LO, ST_IMM_HI, ST_OUT}
      ocdxal_state_t;

   ocdxal_state_t state;
   ocdxal_class_t cls;
   ocdxal_class_t held_cls;
   logic [7:0] opcode;
   logic [7:0] modrm;
   logic [7:0] imm_lo;
   logic [7:0] imm_hi;
   logic illegal;
   logic take;
   logic group_ok;
   ocdxal_op_t group_op;

   // number of data bytes for an immediate class
   function automatic logic [1:0] imm_bytes(input logic [1:0] kind, input logic [7:0] op);
      begin
         if (kind == IMM_BY_W)
            imm_bytes = op[0] ? 2'h2 : 2'h1;
         else if (kind == IMM_BY_SW)
            imm_bytes = (op[1:0] == 2'b01) ? 2'h2 : 2'h1;
         else
            imm_bytes = 2'h0;
      end
   endfunction

   ocdxal_first_byte ocdxal_first_byte_inst (
      .opcode(in_byte),
      .cls(cls)
   );

   assign in_ready = state != ST_OUT;
   assign take = in_valid && in_ready;
   assign dec_valid = state == ST_OUT;

   // sub-opcode resolution of shared groups
   always_comb
   begin
      group_op = held_cls.op;
      group_ok = 1'b1;
      if (opcode[7:2] == GRP_IMM)
      begin
         case (in_byte[5:3])
            SUB_2: group_op = OPR_SUM_WITH_CARRY;
            SUB_3: group_op = OPR_DIFFERENCE_WITH_BORROW;
            default: group_ok = 1'b0;
         endcase
      end
      else if (opcode[7:1] == GRP_UNARY)
      begin
         case (in_byte[5:3])
            SUB_4: group_op = OPR_UNSIGNED_PRODUCT;
            SUB_5: group_op = OPR_SIGNED_PRODUCT;
            SUB_6: group_op = OPR_UNSIGNED_QUOTIENT;
            SUB_7: group_op = OPR_SIGNED_QUOTIENT;
            SUB_3: group_op = OPR_SIGN_CHANGE;
            SUB_2: group_op = OPR_INVERT;
            default: group_ok = 1'b0;
         endcase
      end
      else if (opcode[7:2] == GRP_SHIFT)
      begin
         case (in_byte[5:3])
            SUB_4: group_op = OPR_LEFT_SHIFT;
            SUB_5: group_op = OPR_LOGICAL_RIGHT_SHIFT;
            SUB_7: group_op = OPR_SIGNED_RIGHT_SHIFT;
            SUB_0: group_op = OPR_CYCLIC_LEFT;
            SUB_1: group_op = OPR_CYCLIC_RIGHT;
            SUB_2: group_op = OPR_CARRY_CYCLIC_LEFT;
            default: group_ok = 1'b0;
         endcase
      end
      else if (opcode == OP_STACK_STORE)
         group_ok = in_byte[5:3] == SUB_6;
      else if (opcode == OP_STACK_LOAD)
         group_ok = in_byte[5:3] == SUB_0;
      else if (opcode == OP_RM_TO_SEG || opcode == OP_SEG_TO_RM)
         group_ok = !in_byte[5];
   end

   // byte sequencing
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         state <= ST_OPCODE;
      else
      begin
         case (state)
            ST_OPCODE:
               if (take)
               begin
                  if (!cls.known)
                     state <= ST_OUT;
                  else if (cls.needs_second_const)
                     state <= ST_CONST;
                  else if (cls.needs_modrm)
                     state <= ST_MODRM;
                  else if (imm_bytes(cls.imm_kind, in_byte) != 2'h0)
                     state <= ST_IMM_LO;
                  else
                     state <= ST_OUT;
               end
            ST_MODRM:
               if (take)
               begin
                  if (group_ok && imm_bytes(held_cls.imm_kind, opcode) != 2'h0)
                     state <= ST_IMM_LO;
                  else
                     state <= ST_OUT;
               end
            ST_CONST:
               if (take)
                  state <= ST_OUT;
            ST_IMM_LO:
               if (take)
                  state <= (imm_bytes(held_cls.imm_kind, opcode) == 2'h2) ? ST_IMM_HI : ST_OUT;
            ST_IMM_HI:
               if (take)
                  state <= ST_OUT;
            ST_OUT:
               if (dec_ready)
                  state <= ST_OPCODE;
            default:
               state <= ST_OPCODE;
         endcase
      end
   end

   // captured bytes and decode outcome
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         opcode <= 8'h00;
         modrm <= 8'h00;
         imm_lo <= 8'h00;
         imm_hi <= 8'h00;
         illegal <= 1'b0;
         held_cls <= '{known: 1'b0, needs_modrm: 1'b0, needs_second_const: 1'b0,
                       imm_kind: IMM_NONE, op: OPR_NONE};
      end
      else if (take)
      begin
         case (state)
            ST_OPCODE:
            begin
               opcode <= in_byte;
               held_cls <= cls;
               modrm <= 8'h00;
               imm_lo <= 8'h00;
               imm_hi <= 8'h00;
               illegal <= !cls.known;
            end
            ST_MODRM:
            begin
               modrm <= in_byte;
               held_cls.op <= group_ok ? group_op : OPR_NONE;
               illegal <= !group_ok;
            end
            ST_CONST:
               if (in_byte != ASCII_ADJ_BASE)
               begin
                  // not a recognised adjust form
                  held_cls.op <= OPR_NONE;
                  illegal <= 1'b1;
               end
            ST_IMM_LO:
               imm_lo <= in_byte;
            ST_IMM_HI:
               imm_hi <= in_byte;
            default:
               illegal <= illegal;
         endcase
      end
   end

   // decoded fields; sign extension of a short immediate left to the datapath
   always_comb
   begin
      dec.op = held_cls.op;
      dec.word_size = opcode[0];
      dec.to_reg = opcode[1];
      dec.sign_ext = opcode[1];
      dec.count_in_reg = opcode[1];
      dec.addressing_kind = modrm[7:6];
      dec.gpr_index = modrm[5:3];
      dec.operand_field = modrm[2:0];
      dec.immediate = {imm_hi, imm_lo};
      dec_illegal = illegal && dec_valid;
   end

endmodule

// file: testbench/ocdxal_feeder.sv
// feeder model: prefetch queue side and datapath acceptance
// assumes the decoder takes a byte on a rising edge with valid and ready high
`timescale 1ns/1ps
module ocdxal_feeder
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // byte stream to the decoder
   output logic [7:0] in_byte,
   output logic in_valid,
   input wire logic in_ready,
   // decoded result handshake
   input wire logic dec_valid,
   output logic dec_ready
);
   logic [7:0] q[$];
   int ready_delay = 0;
   int held = 0;
   initial
   begin
      in_byte = 8'h00;
      in_valid = 1'h0;
      dec_ready = 1'h0;
   end
   task automatic put(input logic [7:0] b);
      q.push_back(b);
   endtask
   always @(posedge ref_clk)
   begin
      if (!rst && in_valid && in_ready)
         void'(q.pop_front());
      held = (dec_valid && !dec_ready) ? held + 1 : 0;
      #1;
      in_valid = q.size() > 0;
      // idle line toggles so a stale byte never passes for fresh data
      in_byte = in_valid ? q[0] : ~in_byte;
      dec_ready = dec_valid && held >= ready_delay;
   end
endmodule

// file: testbench/ocdxal_decoder_properties.sv
// assertions on the opcode decoder ports
// assumes a bind to the decoder top, one clock, synchronous reset
`timescale 1ns/1ps
module ocdxal_decoder_props
   import ocdxal_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // byte stream
   input wire logic [7:0] in_byte,
   input wire logic in_valid,
   input wire logic in_ready,
   // decoded output
   input wire ocdxal_decoded_t dec,
   input wire logic dec_valid,
   input wire logic dec_ready,
   input wire logic dec_illegal
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   logic [2:0] pos;
   logic [7:0] first_q;
   logic [7:0] last_q;
   logic take;
   logic opener;
   logic second;
   assign take = in_valid && in_ready;
   assign opener = take && pos == 3'h0;
   assign second = take && pos == 3'h1;
   // byte position inside the instruction being gathered
   always_ff @(posedge ref_clk)
   begin
      if (rst || (dec_valid && dec_ready))
         pos <= 3'h0;
      else if (take)
         pos <= pos + 3'h1;
      if (take)
         last_q <= in_byte;
      if (opener)
         first_q <= in_byte;
   end
   AST_SEG_TO: assert property (second && first_q == OP_RM_TO_SEG && !in_byte[5]
      |=> dec_valid && dec.op == OPR_MOVE_TO_SEG) else $error("segment move lost");
   AST_SEG_BAD: assert property (second && first_q == OP_RM_TO_SEG && in_byte[5]
      |=> dec_valid && dec_illegal) else $error("segment move bit not refused");
   AST_LOOKUP: assert property (opener && in_byte == OP_TABLE_LOOKUP
      |=> dec_valid && dec.op == OPR_TABLE_LOOKUP_BYTE) else $error("table lookup lost");
   AST_FLAGS: assert property (opener && in_byte == OP_HIGH_TO_FLAGS
      |=> dec_valid && dec.op == OPR_HIGH_BYTE_TO_FLAGS) else $error("flag store lost");
   AST_EXTEND: assert property (opener && in_byte[7:1] == 7'h4C
      |=> dec_valid && dec.op ==
      (last_q[0] ? OPR_WORD_TO_DOUBLE_EXTEND : OPR_BYTE_TO_WORD_EXTEND)) else $error("extend");
   AST_PROD: assert property (second && first_q[7:1] == GRP_UNARY
      && in_byte[5:3] == SUB_4
      |=> dec.op == OPR_UNSIGNED_PRODUCT && dec.word_size == first_q[0]) else $error("product");
   AST_ASCII_ADJ: assert property (second && first_q == OP_ASCII_PROD
      |=> dec_valid && dec_illegal == (last_q != ASCII_ADJ_BASE)) else $error("ascii fix");
   AST_SIGNED_RSHIFT: assert property (second && first_q[7:2] == GRP_SHIFT
      && in_byte[5:3] == SUB_7
      |=> dec.op == OPR_SIGNED_RIGHT_SHIFT && dec.count_in_reg == first_q[1])
      else $error("signed right shift lost");
   AST_IMM_WORD: assert property (take && pos == 3'h3
      && first_q == {GRP_IMM, 2'h1}
      |=> dec_valid && dec.immediate == {last_q, $past(last_q)}) else $error("word data");
   cover property (opener && in_byte == OP_TABLE_LOOKUP);
   cover property (dec_valid && dec_illegal);
   cover property (take && pos == 3'h3);
endmodule
bind ocdxal_decoder ocdxal_decoder_props ocdxal_decoder_props_inst (.ref_clk(ref_clk),
   .rst(rst), .in_byte(in_byte), .in_valid(in_valid), .in_ready(in_ready), .dec(dec),
   .dec_valid(dec_valid), .dec_ready(dec_ready), .dec_illegal(dec_illegal));

// file: testbench/ocdxal_decoder_bench.sv
// self-checking bench for the opcode decoder
// assumes the feeder model drives the byte stream and the result handshake
`timescale 1ns/1ps
module ocdxal_decoder_bench
   import ocdxal_pkg::*;
();
   logic ref_clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] in_byte;
   logic in_valid, in_ready, dec_valid, dec_ready, dec_illegal;
   ocdxal_decoded_t dec, seen;
   int error_cnt = 0, total_checks = 0, cycles = 0;
   ocdxal_decoder ocdxal_decoder_inst (.ref_clk(ref_clk), .rst(rst), .in_byte(in_byte),
      .in_valid(in_valid), .in_ready(in_ready), .dec(dec), .dec_valid(dec_valid),
      .dec_ready(dec_ready), .dec_illegal(dec_illegal));
   ocdxal_feeder ocdxal_feeder_inst (.ref_clk(ref_clk), .rst(rst), .in_byte(in_byte),
      .in_valid(in_valid), .in_ready(in_ready), .dec_valid(dec_valid), .dec_ready(dec_ready));
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic test_done;
      if (error_cnt == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // hang guard, far above the few hundred cycles the sequence needs
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         error_cnt++;
         test_done();
      end
   end
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, got);
      end
   endtask
   // first byte sits in the low byte of b; waits are bounded
   task automatic ins(input logic [31:0] b, input int n, input ocdxal_op_t eop,
      input logic [15:0] eimm = 16'h0);
      int k;
      for (k = 0; k < n; k++)
         ocdxal_feeder_inst.put(b[8*k +: 8]);
      for (k = 0; k < 40 && dec_valid !== 1'h1; k++)
         @(posedge ref_clk) #2;
      seen = dec;
      check("op", seen.op, eop);
      check("illegal", dec_illegal, eop == OPR_NONE);
      check("immediate", seen.immediate, eimm);
      check("refused", in_ready, 1'h0);
      for (k = 0; k < 40 && dec_valid !== 1'h0; k++)
         @(posedge ref_clk) #2;
   endtask
   task automatic t_transfer;
      ins(32'hD88E, 2, OPR_MOVE_TO_SEG);
      ins(32'hE08E, 2, OPR_NONE);
      ins(32'hC08C, 2, OPR_MOVE_FROM_SEG);
      ins(32'hD7, 1, OPR_TABLE_LOOKUP_BYTE);
      ins(32'h088D, 2, OPR_EFFECTIVE_OFFSET_LOAD);
      check("gpr", seen.gpr_index, 3'h1);
      ins(32'h1EC5, 2, OPR_POINTER_LOAD_DATASEG);
      ins(32'h1EC4, 2, OPR_POINTER_LOAD_EXTRASEG);
      ins(32'h9F, 1, OPR_FLAGS_TO_HIGH_BYTE);
      ins(32'h9E, 1, OPR_HIGH_BYTE_TO_FLAGS);
      ins(32'h36FF, 2, OPR_STACK_STORE);
      ins(32'hC08F, 2, OPR_STACK_LOAD);
   endtask
   task automatic t_arith;
      ins(32'hC010, 2, OPR_SUM_WITH_CARRY);
      ins(32'h05D080, 3, OPR_SUM_WITH_CARRY, 16'h0005);
      ins(32'h1234D081, 4, OPR_SUM_WITH_CARRY, 16'h1234);
      ins(32'h0714, 2, OPR_SUM_WITH_CARRY, 16'h0007);
      ins(32'h123415, 3, OPR_SUM_WITH_CARRY, 16'h1234);
      ins(32'h16, 1, OPR_NONE);
      ins(32'hC080, 2, OPR_NONE);
      ins(32'h37, 1, OPR_ASCII_SUM_FIX);
      ins(32'h27, 1, OPR_BCD_SUM_FIX);
      ins(32'hC02B, 2, OPR_DIFFERENCE);
      ins(32'hC018, 2, OPR_DIFFERENCE_WITH_BORROW);
      ins(32'h01D883, 3, OPR_DIFFERENCE_WITH_BORROW, 16'h0001);
      ins(32'h091C, 2, OPR_DIFFERENCE_WITH_BORROW, 16'h0009);
      ins(32'h12341D, 3, OPR_DIFFERENCE_WITH_BORROW, 16'h1234);
      ins(32'h3F, 1, OPR_ASCII_DIFFERENCE_FIX);
      ins(32'h2F, 1, OPR_BCD_DIFFERENCE_FIX);
      ins(32'h98, 1, OPR_BYTE_TO_WORD_EXTEND);
      ins(32'h99, 1, OPR_WORD_TO_DOUBLE_EXTEND);
   endtask
   task automatic t_muldiv;
      ins(32'hE0F6, 2, OPR_UNSIGNED_PRODUCT);
      ins(32'hE8F7, 2, OPR_SIGNED_PRODUCT);
      ins(32'hF0F7, 2, OPR_UNSIGNED_QUOTIENT);
      ins(32'hF8F6, 2, OPR_SIGNED_QUOTIENT);
      ins(32'hD8F6, 2, OPR_SIGN_CHANGE);
      ins(32'hD0F6, 2, OPR_INVERT);
      ins(32'h0AD4, 2, OPR_ASCII_PRODUCT_FIX);
      ins(32'h0BD4, 2, OPR_NONE);
      ins(32'h0AD5, 2, OPR_ASCII_QUOTIENT_PREP);
      ins(32'h00D5, 2, OPR_NONE);
   endtask
   task automatic t_shift;
      ins(32'hE0D0, 2, OPR_LEFT_SHIFT);
      ins(32'hE8D3, 2, OPR_LOGICAL_RIGHT_SHIFT);
      check("count", seen.count_in_reg, 1'h1);
      ins(32'hF8D1, 2, OPR_SIGNED_RIGHT_SHIFT);
      ins(32'hC0D2, 2, OPR_CYCLIC_LEFT);
      ins(32'hC8D0, 2, OPR_CYCLIC_RIGHT);
      ins(32'hD0D0, 2, OPR_CARRY_CYCLIC_LEFT);
      ins(32'hD8D0, 2, OPR_NONE);
   endtask
   // datapath slow to accept, fields checked at the packed positions
   task automatic t_stall;
      ocdxal_feeder_inst.ready_delay = 4;
      ins(32'hD113, 2, OPR_SUM_WITH_CARRY);
      check("fields", seen[27:16], 12'hFD1);
      ins(32'h0A10, 2, OPR_SUM_WITH_CARRY);
      check("fields", seen[27:16], 12'h00A);
      ocdxal_feeder_inst.ready_delay = 0;
   endtask
   // half-gathered opcode must be forgotten across a reset
   task automatic t_reset;
      ocdxal_feeder_inst.put(8'hD4);
      repeat (3) @(posedge ref_clk);
      #1 rst = 1'h1;
      repeat (2) @(posedge ref_clk);
      #1 rst = 1'h0;
      check("valid after reset", dec_valid, 1'h0);
      check("ready after reset", in_ready, 1'h1);
      ins(32'hD7, 1, OPR_TABLE_LOOKUP_BYTE);
   endtask
   initial
   begin
      repeat (16) @(posedge ref_clk);
      #1 rst = 1'h0;
      t_transfer();
      t_arith();
      t_muldiv();
      t_shift();
      t_stall();
      t_reset();
      test_done();
   end
endmodule
